// ---- inc/hstx_pkg.sv ----
// constants and types of the harvested switch telegram transmitter
package hstx_pkg;

    localparam int unsigned CLK_HZ       = 200_000_000;
    localparam int unsigned BIT_RATE_BPS = 120_000;
    localparam int unsigned BIT_CYC      = CLK_HZ / BIT_RATE_BPS;
    localparam int unsigned BURST_US     = 700;
    localparam int unsigned FRAME_BITS   = BURST_US * (BIT_RATE_BPS / 1000) / 1000;
    localparam int unsigned CYCLE_MS     = 20;
    localparam int unsigned CYCLE_CYC    = CYCLE_MS * (CLK_HZ / 1000);
    localparam int unsigned GAP1_US      = 2000;
    localparam int unsigned GAP1_CYC     = GAP1_US * (CLK_HZ / 1_000_000);
    localparam int unsigned GAPR_US      = 2000;
    localparam int unsigned GAPR_CYC     = GAPR_US * (CLK_HZ / 1_000_000);
    localparam int unsigned STEP_NS      = 50_000;
    localparam int unsigned STEP_CYC     = STEP_NS / (1_000_000_000 / CLK_HZ);
    localparam int unsigned SUBTELE_NUM  = 3;

    localparam logic [7:0]  ORIGIN_CODE  = 8'h05;
    localparam logic [3:0]  REPEAT_CNT   = 4'h0;
    localparam logic [31:0] ID_DEFAULT   = 32'h1234_5678; // arbitrary value

    localparam logic [7:0]  REG_CTRL     = 8'h00;
    localparam logic [7:0]  REG_STATUS   = 8'h04;
    localparam logic [7:0]  REG_ID       = 8'h08;
    localparam logic [7:0]  REG_COUNT    = 8'h0c;
    localparam logic [7:0]  REG_SEED     = 8'h10;
    localparam int unsigned CTRL_EN_BIT  = 0;
    localparam logic        CTRL_EN_RST  = 1'b1;

    localparam logic [15:0] LFSR_RST     = 16'hace1;
    localparam logic [15:0] LFSR_TAPS    = 16'hb400;

    typedef enum logic [1:0] {
        S_IDLE  = 2'b00,
        S_BURST = 2'b01,
        S_GAP   = 2'b10
    } hstx_state_t;

    typedef struct packed {
        logic on;
        logic off;
        logic pol;
    } hstx_sample_t;

    typedef struct packed {
        logic [7:0]  origin;
        logic [7:0]  top;
        logic [7:0]  second;
        logic [7:0]  third;
        logic [7:0]  low;
        logic [31:0] id;
        logic [7:0]  status;
    } hstx_tele_t;

    localparam int unsigned PRE_BITS = FRAME_BITS - $bits(hstx_tele_t);
    localparam logic [PRE_BITS-1:0] PREAMBLE = {(PRE_BITS / 2){2'b10}};

endpackage

// ---- rtl/hstx_top.sv ----
// telegram framer and scheduler with apb control for a pulse powered switch
`timescale 1ns/1ps
module hstx_top #(
    parameter logic [31:0] MODULE_ID  = hstx_pkg::ID_DEFAULT,
    parameter int unsigned CYCLE_LEN  = hstx_pkg::CYCLE_CYC,
    parameter int unsigned GAP1_LEN   = hstx_pkg::GAP1_CYC,
    parameter int unsigned GAPR_LEN   = hstx_pkg::GAPR_CYC,
    parameter int unsigned STEP_LEN   = hstx_pkg::STEP_CYC,
    parameter int unsigned BIT_LEN    = hstx_pkg::BIT_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        energy_input_a,
    input  wire logic        energy_input_b,
    input  wire logic        switch_input_on,
    input  wire logic        switch_input_off,
    output logic             carrier_on,
    output logic             cycle_busy
);
    import hstx_pkg::*;

    hstx_state_t             state_r;
    hstx_state_t             state_nxt;
    hstx_sample_t            samp_r;
    hstx_sample_t            samp_w;
    hstx_tele_t              tele_w;
    logic [FRAME_BITS-1:0]   frame_r;
    logic [FRAME_BITS-1:0]   shift_r;
    logic [10:0]             baud_cnt_r;
    logic [6:0]              bit_cnt_r;
    logic [1:0]              burst_idx_r;
    logic [31:0]             gap_cnt_r;
    logic [31:0]             gap_load_w;
    logic [31:0]             cyc_cnt_r;
    logic [31:0]             burst_cyc_r;
    logic [15:0]             lfsr_r;
    logic [7:0]              rnd_r;
    logic                    pulse_d_r;
    logic                    ctrl_en_r;
    logic [15:0]             done_cnt_r;
    logic [15:0]             drop_cnt_r;
    logic [31:0]             prdata_r;

    ////////////////////////////////////////////////////////////////////////////
    // trigger and telegram assembly

    wire pulse_w    = energy_input_a ^ energy_input_b;
    wire rise_w     = pulse_w & ~pulse_d_r;
    wire start_w    = rise_w & (state_r == S_IDLE) & ctrl_en_r;
    // a pulse during a cycle has no supply of its own to start another one
    wire drop_w     = rise_w & ~start_w;

    // switches are trusted stable around the pulse edge, sampled once
    assign samp_w.on  = switch_input_on;
    assign samp_w.off = switch_input_off;
    assign samp_w.pol = energy_input_a & ~energy_input_b;

    assign tele_w.origin = ORIGIN_CODE;
    assign tele_w.top    = {2'b00, samp_w.off, samp_w.pol, 3'b000, samp_w.on & samp_w.off};
    assign tele_w.second = 8'h00;
    assign tele_w.third  = 8'h00;
    assign tele_w.low    = 8'h00;
    assign tele_w.id     = MODULE_ID;
    assign tele_w.status = {2'b00, 1'b1, samp_w.on | samp_w.off, REPEAT_CNT};

    ////////////////////////////////////////////////////////////////////////////
    // burst scheduler

    wire in_burst_w  = (state_r == S_BURST);
    // the 11-bit baud counter limits one bit to at most 2048 clocks
    wire bit_end_w   = in_burst_w & (baud_cnt_r == 11'(BIT_LEN - 1));
    wire last_bit_w  = (bit_cnt_r == 7'(FRAME_BITS - 1));
    wire burst_end_w = bit_end_w & last_bit_w;
    wire gap_end_w   = (state_r == S_GAP) & (gap_cnt_r == 32'h0000_0000);
    wire final_w     = burst_idx_r == 2'(SUBTELE_NUM - 1);

    // second gap is random; the widest draw still ends inside the window
    assign gap_load_w = (burst_idx_r == 2'h0) ? 32'(GAP1_LEN - 1) :
                        32'(GAPR_LEN - 1) + 32'(rnd_r) * 32'(STEP_LEN);

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            S_IDLE:  if (start_w) state_nxt = S_BURST;
            S_BURST: if (burst_end_w) state_nxt = final_w ? S_IDLE : S_GAP;
            S_GAP:   if (gap_end_w) state_nxt = S_BURST;
            default: state_nxt = S_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r     <= S_IDLE;
            pulse_d_r   <= 1'b0;
            burst_idx_r <= 2'h0;
        end else begin
            state_r   <= state_nxt;
            pulse_d_r <= pulse_w;
            if (start_w)
                burst_idx_r <= 2'h0;
            else if (burst_end_w)
                burst_idx_r <= burst_idx_r + 2'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            samp_r  <= '0;
            frame_r <= '0;
            shift_r <= '0;
        end else if (start_w) begin
            samp_r  <= samp_w;
            frame_r <= {PREAMBLE, tele_w};
            shift_r <= {PREAMBLE, tele_w};
        end else if (gap_end_w) begin
            shift_r <= frame_r;
        end else if (bit_end_w) begin
            shift_r <= {shift_r[FRAME_BITS-2:0], 1'b0};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            baud_cnt_r <= 11'h000;
            bit_cnt_r  <= 7'h00;
        end else if (start_w || gap_end_w || bit_end_w) begin
            baud_cnt_r <= 11'h000;
            bit_cnt_r  <= bit_end_w ? bit_cnt_r + 7'h01 : 7'h00;
        end else if (in_burst_w) begin
            baud_cnt_r <= baud_cnt_r + 11'h001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            gap_cnt_r <= 32'h0000_0000;
        else if (burst_end_w)
            gap_cnt_r <= gap_load_w;
        else if (state_r == S_GAP)
            gap_cnt_r <= gap_cnt_r - 32'h0000_0001;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            cyc_cnt_r <= 32'h0000_0000;
        else if (start_w)
            cyc_cnt_r <= 32'h0000_0000;
        else if (state_r != S_IDLE)
            cyc_cnt_r <= cyc_cnt_r + 32'h0000_0001;
    end

    // clocks spent in the current burst, read only by the checks
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            burst_cyc_r <= 32'h0000_0000;
        else if (start_w || gap_end_w)
            burst_cyc_r <= 32'h0000_0000;
        else if (in_burst_w)
            burst_cyc_r <= burst_cyc_r + 32'h0000_0001;
    end

    // ook keying straight from the shift register head
    assign carrier_on = in_burst_w & shift_r[FRAME_BITS-1];
    assign cycle_busy = (state_r != S_IDLE);

    ////////////////////////////////////////////////////////////////////////////
    // random source and apb registers

    wire wr_w     = psel & penable & pwrite;
    wire setup_w  = psel & ~penable;
    wire hit_w    = (paddr[7:0] == REG_CTRL) | (paddr[7:0] == REG_STATUS) |
                    (paddr[7:0] == REG_ID) | (paddr[7:0] == REG_COUNT) |
                    (paddr[7:0] == REG_SEED);
    wire hit_w_ok = hit_w & (paddr[31:8] == 24'h00_0000);
    wire seed_w   = wr_w & hit_w_ok & (paddr[7:0] == REG_SEED);
    wire lfsr_fb  = ^(lfsr_r & LFSR_TAPS);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            lfsr_r <= LFSR_RST;
        else if (seed_w)
            lfsr_r <= (pwdata[15:0] == 16'h0000) ? LFSR_RST : pwdata[15:0];
        else
            lfsr_r <= {lfsr_r[14:0], lfsr_fb};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            rnd_r <= 8'h00;
        else if (start_w)
            rnd_r <= lfsr_r[7:0];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_en_r  <= CTRL_EN_RST;
            done_cnt_r <= 16'h0000;
            drop_cnt_r <= 16'h0000;
        end else begin
            if (wr_w && hit_w_ok && paddr[7:0] == REG_CTRL)
                ctrl_en_r <= pwdata[CTRL_EN_BIT];
            if (burst_end_w && final_w)
                done_cnt_r <= done_cnt_r + 16'h0001;
            if (drop_w)
                drop_cnt_r <= drop_cnt_r + 16'h0001;
        end
    end

    wire [31:0] status_w = {16'h0000, rnd_r, 1'b0, samp_r.pol, samp_r.off, samp_r.on,
                            burst_idx_r, state_r};
    wire [31:0] rd_w = (paddr[7:0] == REG_CTRL)   ? {31'h0, ctrl_en_r} :
                       (paddr[7:0] == REG_STATUS) ? status_w :
                       (paddr[7:0] == REG_ID)     ? MODULE_ID :
                       (paddr[7:0] == REG_COUNT)  ? {drop_cnt_r, done_cnt_r} :
                       (paddr[7:0] == REG_SEED)   ? {16'h0000, lfsr_r} : 32'h0000_0000;

    // read data is caught in the setup cycle so the slave never waits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            prdata_r <= 32'h0000_0000;
        else if (setup_w && !pwrite)
            prdata_r <= hit_w_ok ? rd_w : 32'h0000_0000;
    end

    assign prdata  = prdata_r;
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~hit_w_ok;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence burst_done_s;
        burst_end_w && !final_w;
    endsequence

    sequence gap_run_s;
        (state_r == S_GAP) [*3];
    endsequence

    sequence first_gap_s;
        burst_done_s ##0 (burst_idx_r == 2'h0);
    endsequence

    one_cycle_a: assert property (start_w |=> in_burst_w && burst_idx_r == 2'h0
                                  && cyc_cnt_r == 32'h0)
        else $error("pulse did not start a cycle");

    three_bursts_a: assert property (burst_end_w && final_w |=> state_r == S_IDLE
                                     && burst_idx_r == 2'h3)
        else $error("cycle did not end after third burst");

    same_bits_a: assert property (gap_end_w |=> shift_r == frame_r)
        else $error("subtelegram content differs");

    burst_len_a: assert property (burst_end_w |-> burst_cyc_r == 32'(FRAME_BITS * BIT_LEN - 1))
        else $error("burst length wrong");

    window_a: assert property (cycle_busy |-> cyc_cnt_r < 32'(CYCLE_LEN))
        else $error("burst outside cycle window");

    gap_draw_a: assert property (burst_done_s ##0 (burst_idx_r == 2'h1) |=> gap_run_s
                                 ##0 ($past(gap_cnt_r, 2) == 32'(GAPR_LEN - 1)
                                 + 32'(rnd_r) * 32'(STEP_LEN)))
        else $error("random gap not from drawn value");

    seed_take_a: assert property (start_w |=> rnd_r == $past(lfsr_r[7:0]))
        else $error("random draw not sampled at start");

    ask_key_a: assert property (!in_burst_w |-> !carrier_on)
        else $error("carrier on outside burst");

    bit_rate_a: assert property (in_burst_w && $changed(bit_cnt_r) && bit_cnt_r != 7'h0
                                 |-> $past(baud_cnt_r) == 11'(BIT_LEN - 1))
        else $error("bit period wrong");

    id_zero_a: assert property (start_w |=> frame_r[79:0] == {ORIGIN_CODE,
                                $past(tele_w.top), 24'h0, MODULE_ID, $past(tele_w.status)})
        else $error("id or zero bytes wrong");

    top_code_a: assert property (start_w |=> frame_r[71:64] == {2'b00,
                                 $past(switch_input_off), samp_r.pol, 3'b000,
                                 $past(switch_input_on & switch_input_off)})
        else $error("top payload byte wrong");

    status_code_a: assert property (start_w |=> frame_r[7:0] == {3'b001,
                                    $past(switch_input_on | switch_input_off), REPEAT_CNT})
        else $error("status byte wrong");

    polarity_a: assert property (start_w |=> samp_r.pol ==
                                 $past(energy_input_a && !energy_input_b))
        else $error("polarity bit wrong");

    // gap counters load on the burst end edge, so the checks look one clock later
    gap_first_a: assert property (first_gap_s |=> gap_cnt_r == 32'(GAP1_LEN - 1))
        else $error("first gap length wrong");

    gap_fits_a: assert property (burst_done_s ##0 (burst_idx_r == 2'h1) |=>
                                 cyc_cnt_r + gap_cnt_r + 32'(FRAME_BITS * BIT_LEN)
                                 < 32'(CYCLE_LEN))
        else $error("random gap overruns the cycle window");

    // a late pulse must not zero the cycle timer
    restart_a: assert property (rise_w && cycle_busy |=> cyc_cnt_r != 32'h0)
        else $error("pulse during a cycle restarted it");

    frame_hold_a: assert property (cycle_busy |=> $stable(frame_r))
        else $error("telegram changed inside a cycle");

    samp_hold_a: assert property (cycle_busy |=> $stable(samp_r))
        else $error("switch sample changed inside a cycle");

    keying_a: assert property (in_burst_w && shift_r[FRAME_BITS-1] |-> carrier_on)
        else $error("carrier off during a one bit");

endmodule

// ---- verification/hstx_rx_model.sv ----
// receiver model that turns the keyed carrier back into frames
`timescale 1ns/1ps
module hstx_rx_model
    import hstx_pkg::*;
#(
    parameter int unsigned BIT_LEN = BIT_CYC
) (
    input  wire logic                  pclk,
    input  wire logic                  carrier_on,
    input  wire logic [63:0]           cyc,
    output logic      [FRAME_BITS-1:0] frame_q,
    output int unsigned                n_frames,
    output int unsigned                n_rises,
    output logic      [63:0]           t_start
);
    logic prev_q;
    ////////////////////////////////////////////////////////////////////////////////
    // sampled on the clock, so a zero-width glitch never counts as an edge
    always @(posedge pclk) begin
        if (carrier_on === 1'b1 && prev_q !== 1'b1) n_rises++;
        prev_q <= carrier_on;
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        n_frames = 0;
        n_rises  = 0;
        prev_q   = 1'b0;
        forever begin
            @(posedge pclk iff carrier_on === 1'b1);
            t_start = cyc;
            // mid-bit sampling leaves half a bit of margin either way
            repeat (BIT_LEN / 2) @(posedge pclk);
            for (int i = FRAME_BITS - 1; i >= 0; i--) begin
                frame_q[i] = carrier_on;
                if (i > 0) repeat (BIT_LEN) @(posedge pclk);
            end
            repeat (BIT_LEN / 2) @(posedge pclk);
            n_frames++;
        end
    end
endmodule

// ---- verification/hstx_top_tb.sv ----
// self-checking bench of the switch telegram transmitter
`timescale 1ns/1ps
`define CHK(a, x) begin num_checks++; if ((a) !== (x)) begin miscompares++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (x)); end end
module hstx_top_tb;
    import hstx_pkg::*;
    localparam logic [31:0] MOD_ID  = 32'h0bad_cafe; // arbitrary value
    localparam int unsigned CYC_LEN = 6000;
    // bit time, setup and trigger spacing scaled down like the gaps
    localparam int unsigned BL      = 16;
    localparam int unsigned HOLD    = 200;
    localparam int unsigned G1      = 100;
    localparam int unsigned GR      = 100;
    localparam int unsigned ST      = 4;
    localparam int unsigned F_CYC   = FRAME_BITS * BL;
    logic                  pclk = 1'b0, presetn = 1'b0, psel = 1'b0;
    logic                  penable = 1'b0, pwrite = 1'b0, pready, pslverr;
    logic [31:0]           paddr = '0, pwdata = '0, prdata, q;
    logic                  ea = 1'b0, eb = 1'b0, sw_on = 1'b0, sw_off = 1'b0;
    logic                  carrier_on, cycle_busy, e;
    logic [63:0]           cyc = '0, t_rx, g_a, g_b;
    logic [FRAME_BITS-1:0] rx_frame;
    int unsigned           rx_n, rx_rises, miscompares = 0, num_checks = 0;

    hstx_top #(.MODULE_ID(MOD_ID), .CYCLE_LEN(CYC_LEN), .GAP1_LEN(G1), .GAPR_LEN(GR),
        .STEP_LEN(ST), .BIT_LEN(BL)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .energy_input_a(ea), .energy_input_b(eb),
        .switch_input_on(sw_on), .switch_input_off(sw_off), .carrier_on, .cycle_busy);
    hstx_rx_model #(.BIT_LEN(BL)) i_rx (.pclk, .carrier_on, .cyc, .frame_q(rx_frame),
        .n_frames(rx_n),
        .n_rises(rx_rises), .t_start(t_rx));

    always #2.5 pclk = ~pclk;
    always @(posedge pclk) cyc <= cyc + 1;
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [FRAME_BITS-1:0] exp_frame(input logic on, off, p);
        hstx_tele_t t;
        t = '{origin: ORIGIN_CODE, top: {2'b00, off, p, 3'b000, on & off}, second: 8'h00,
              third: 8'h00, low: 8'h00, id: MOD_ID, status: {2'b00, 1'b1, on | off, REPEAT_CNT}};
        return {PREAMBLE, t};
    endfunction
    function automatic int unsigned rises(input logic [FRAME_BITS-1:0] f);
        rises = 0;
        for (int i = 0; i < FRAME_BITS; i++)
            if (f[i] && (i == FRAME_BITS - 1 || !f[i+1])) rises++;
    endfunction
    task automatic report_and_stop();
        $display("checks=%0d miscompares=%0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [31:0] a, d, output logic [31:0] r,
                       output logic er);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic fire(input logic on, off, p);
        @(posedge pclk);
        sw_on <= on;
        sw_off <= off;
        repeat (HOLD) @(posedge pclk);
        ea <= p;
        eb <= !p;
    endtask
    task automatic wait_rx(input int unsigned n, output logic [63:0] t);
        for (int k = 0; k < 2 * F_CYC + GR + 256 * ST && rx_n < n; k++) @(posedge pclk);
        `CHK(rx_n >= n, 1'b1)
        t = t_rx;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        apb(1'b0, 32'(REG_ID), '0, q, e);
        `CHK(q, MOD_ID)
        apb(1'b1, 32'(REG_ID), '0, q, e);
        apb(1'b0, 32'(REG_ID), '0, q, e);
        `CHK(q, MOD_ID)
        apb(1'b0, 32'h0000_0100, '0, q, e);
        `CHK({e, q}, {1'b1, 32'h0})
        apb(1'b0, 32'(REG_CTRL), '0, q, e);
        `CHK(q[CTRL_EN_BIT], CTRL_EN_RST)
    endtask
    task automatic t_full(input logic on, off, p, output logic [63:0] g2);
        logic [63:0] t0, t1, t2, t3;
        logic [31:0] c0;
        int unsigned r0;
        logic [FRAME_BITS-1:0] x;
        x = exp_frame(on, off, p);
        apb(1'b0, 32'(REG_COUNT), '0, c0, e);
        r0 = rx_rises;
        fire(on, off, p);
        t0 = cyc;
        wait_rx(rx_n + 1, t1);
        `CHK(rx_frame, x)
        // a second pulse edge mid-cycle must not start another cycle
        ea <= 1'b0;
        eb <= 1'b0;
        @(posedge pclk);
        ea <= p;
        eb <= !p;
        wait_rx(rx_n + 1, t2);
        `CHK(rx_frame, x)
        `CHK(t2 - t1 - F_CYC, 64'(G1))
        wait_rx(rx_n + 1, t3);
        `CHK(rx_frame, x)
        g2 = t3 - t2 - F_CYC - GR;
        `CHK(g2 <= 255 * ST + 3, 1'b1)
        `CHK(g2 % ST, 64'h0)
        for (int k = 0; k < 1000 && cycle_busy === 1'b1; k++) @(posedge pclk);
        `CHK(cycle_busy, 1'b0)
        `CHK(cyc - t0 <= CYC_LEN, 1'b1)
        `CHK(rx_rises - r0, 3 * rises(x))
        apb(1'b0, 32'(REG_COUNT), '0, q, e);
        `CHK(q, {c0[31:16] + 16'h1, c0[15:0] + 16'h1})
        ea <= 1'b0;
        eb <= 1'b0;
    endtask
    task automatic t_first(input logic on, off, p);
        logic [63:0] t1;
        fire(on, off, p);
        wait_rx(rx_n + 1, t1);
        `CHK(rx_frame, exp_frame(on, off, p))
        // reset in the gap cuts the cycle short and saves two bursts of run time
        ea <= 1'b0;
        eb <= 1'b0;
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        `CHK({cycle_busy, carrier_on}, 2'b00)
    endtask
    task automatic t_drop();
        logic [31:0] c0;
        int unsigned n;
        apb(1'b1, 32'(REG_CTRL), '0, q, e);
        apb(1'b0, 32'(REG_COUNT), '0, c0, e);
        n = rx_n;
        fire(1'b1, 1'b0, 1'b1);
        repeat (200) @(posedge pclk);
        `CHK({cycle_busy, rx_n}, {1'b0, n})
        apb(1'b0, 32'(REG_COUNT), '0, q, e);
        `CHK(q[31:16], c0[31:16] + 16'h1)
        ea <= 1'b0;
        eb <= 1'b0;
        apb(1'b1, 32'(REG_CTRL), 32'h1, q, e);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        apb(1'b1, 32'(REG_SEED), 32'h0000_0001, q, e);
        t_full(1'b0, 1'b0, 1'b1, g_a);
        apb(1'b1, 32'(REG_SEED), 32'h0000_5a5a, q, e);
        t_full(1'b1, 1'b1, 1'b0, g_b);
        `CHK(g_a != g_b, 1'b1)
        t_first(1'b1, 1'b0, 1'b1);
        t_first(1'b0, 1'b1, 1'b0);
        t_drop();
        report_and_stop();
    end
    initial begin
        repeat (40_000) @(posedge pclk);
        miscompares++;
        report_and_stop();
    end
endmodule
